// ### bench/pfsg_far.sv
`timescale 1ns/1ns
module pfsg_far (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [2:0] a_ext_i,
    input  wire logic [7:0] b_ext_i,
    input  wire logic [2:0] a_out_i,
    input  wire logic [2:0] a_oe_i,
    input  wire logic [7:0] b_out_i,
    input  wire logic [7:0] b_oe_i,
    output logic      [2:0] a_pin_o,
    output logic      [7:0] b_pin_o,
    output logic      [4:0] fn_o
);
    // ******************************************************************
    // pin levels: the block wins where it drives, else the outside world
    // ******************************************************************
    assign a_pin_o = (a_oe_i & a_out_i) | (~a_oe_i & a_ext_i);
    assign b_pin_o = (b_oe_i & b_out_i) | (~b_oe_i & b_ext_i);

    // ******************************************************************
    // on-chip units: outputs keep moving so a stale pick shows up
    // ******************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fn_o <= 5'h05;
        end else begin
            fn_o <= {fn_o[3:0], ~fn_o[4]};
        end
    end
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    localparam logic [11:0] FS = pfsg_pkg::OFS_PORTA_FSEL;
    localparam logic [11:0] AD = pfsg_pkg::OFS_PORTA_DATA;
    localparam logic [11:0] AR = pfsg_pkg::OFS_PORTA_DIR;
    localparam logic [11:0] BD = pfsg_pkg::OFS_PORTB_DATA;
    localparam logic [11:0] BR = pfsg_pkg::OFS_PORTB_DIR;
    logic        clk     = 1'b0;
    logic        rst_n   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h0;
    logic [31:0] pwdata  = 32'h0;
    logic [6:0]  c       = 7'h0;
    logic [2:0]  a_ext   = 3'h5;
    logic [7:0]  b_ext   = 8'h5a;
    logic [2:0]  fs      = 3'h0;
    logic [2:0]  dir_a   = 3'h0;
    logic [2:0]  lat_a   = 3'h0;
    logic [7:0]  d8      = 8'h0;
    logic [7:0]  l8      = 8'h0;
    logic [31:0] seed    = 32'h3d6b_2eff;
    logic [2:0]  eoe;
    logic [2:0]  eout;
    logic [3:0]  ein;
    logic [32:0] ex;
    logic [4:0]  fn_d;
    logic [32:0] q[$];
    int          bad_count = 0;
    int          cmp_count = 0;
    wire  [31:0] prdata_w;
    wire         pready_w, pslverr_w, rx_w, irx_w, sck_w, tev_w;
    wire  [2:0]  a_out, a_oe, a_pin;
    wire  [7:0]  b_out, b_oe, b_pin;
    wire  [4:0]  fn;
    wire  [25:0] seen = {b_oe, b_out, a_oe, a_out, rx_w, irx_w, sck_w, tev_w};

    always #50 clk = ~clk;

    pfsg_top DUT (
        .CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata_w),
        .PREADY_O(pready_w), .PSLVERR_O(pslverr_w),
        .INFRARED_SELECT_I(c[6]), .TX_ENABLE_I(c[5]), .RX_ENABLE_I(c[4]),
        .SERIAL_PIN_CONTROL_I(c[3]), .CLOCK_SOURCE_UPPER_I(c[2]),
        .CLOCK_SOURCE_LOWER_I(c[1]), .SYNC_MODE_I(c[0]),
        .SERIAL_TX_I(fn[0]), .INFRARED_TX_I(fn[1]),
        .SERIAL_CLOCK_OUT_I(fn[2]), .TIMER_HIGH_OUT_I(fn[3]),
        .TIMER_LOW_OUT_I(fn[4]), .SERIAL_RX_O(rx_w),
        .INFRARED_RX_O(irx_w), .SERIAL_CLOCK_IN_O(sck_w),
        .TIMER_EVENT_IN_O(tev_w), .PORT_A_IN_I(a_pin),
        .PORT_A_OUT_O(a_out), .PORT_A_OE_O(a_oe), .PORT_B_IN_I(b_pin),
        .PORT_B_OUT_O(b_out), .PORT_B_OE_O(b_oe)
    );

    pfsg_far far (
        .clk_i(clk), .rst_n_i(rst_n), .a_ext_i(a_ext), .b_ext_i(b_ext),
        .a_out_i(a_out), .a_oe_i(a_oe), .b_out_i(b_out), .b_oe_i(b_oe),
        .a_pin_o(a_pin), .b_pin_o(b_pin), .fn_o(fn)
    );

    // ******************************************************************
    // helpers
    // ******************************************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic apb(input logic wr_en, input logic [11:0] ad,
                       input logic [31:0] wd, input logic [32:0] exp);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr_en;
        paddr <= ad;
        pwdata <= wd;
        if (!wr_en) q.push_back(exp);
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready_w !== 1'b1 && n < 40);
        if (pready_w !== 1'b1) begin
            bad_count++;
            wrap_up();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] ad, input logic [7:0] wd);
        apb(1'b1, ad, {24'h0, wd}, 33'h0);
    endtask

    task automatic rd(input logic [11:0] ad, input logic [7:0] exp);
        apb(1'b0, ad, 32'h0, {25'h0, exp});
    endtask

    // expected pin roles from the current settings
    task automatic model;
        logic so;
        logic gp;
        so = !c[2] && (c[0] || c[1]);
        gp = !c[2] && !c[1] && !c[0];
        eoe[2] = fs[2] | c[3] | dir_a[2];
        eout[2] = fs[2] ? fn_d[3] : lat_a[2] & dir_a[2];
        if (!fs[2] && c[3]) eout[2] = c[5] ? fn_d[c[6]] : !c[6];
        eoe[1] = fs[1] | (!c[4] & dir_a[1]);
        eout[1] = fs[1] ? fn_d[4] : !c[4] & lat_a[1] & dir_a[1];
        eoe[0] = !fs[0] & (so | (gp & dir_a[0]));
        eout[0] = !fs[0] & (so ? fn_d[2] : gp & lat_a[0] & dir_a[0]);
        ein[3] = (!fs[1] && c[4] && !c[6]) ? a_pin[1] : 1'b1;
        ein[2] = (!fs[1] && c[4] && c[6]) ? a_pin[1] : 1'b1;
        ein[1] = !fs[0] && c[2] && !c[1] && a_pin[0];
        ein[0] = fs[0] && a_pin[0];
    endtask

    task automatic look;
        #1;
        model();
        ex = {7'h0, d8, l8 & d8, eoe, eout, ein};
        check({7'h0, seen}, ex);
    endtask

    // ******************************************************************
    // read results, oldest note first
    // ******************************************************************
    always @(posedge clk) begin
        fn_d <= fn;
        if (psel && penable && !pwrite && pready_w === 1'b1) begin
            if (q.size() == 0) begin
                bad_count++;
            end else begin
                check({pslverr_w, prdata_w}, q.pop_front());
            end
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(FS, 8'hf8);
        rd(AR, 8'hff);
        rd(BR, 8'hff);
        rd(BD, b_ext);
        apb(1'b0, 12'h0fc, 32'h0, {1'b1, 32'h0});
        look();
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            d8 = seed[7:0];
            l8 = seed[15:8];
            dir_a = seed[18:16];
            lat_a = seed[21:19];
            b_ext <= seed[29:22];
            a_ext <= seed[31:29];
            wr(BR, d8);
            wr(BD, l8);
            wr(AR, {5'h0, dir_a});
            wr(AD, {5'h0, lat_a});
            rd(BD, (l8 & d8) | (b_ext & ~d8));
            rd(BR, 8'hff);
            rd(AD, {5'h1f, (lat_a & dir_a) | (a_ext & ~dir_a)});
            look();
        end
        for (int i = 0; i < 40; i++) begin
            seed = xs(seed);
            if (seed[5]) seed[4] = 1'b0;
            fs = seed[2:0];
            dir_a = seed[12:10];
            lat_a = seed[15:13];
            wr(FS, seed[7:0]);
            wr(AR, {5'h0, dir_a});
            wr(AD, {5'h0, lat_a});
            rd(FS, {5'h1f, fs});
            @(posedge clk);
            c <= seed[9:3];
            a_ext <= seed[18:16];
            repeat (6) @(posedge clk);
            look();
        end
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        fs = 3'h0;
        dir_a = 3'h0;
        lat_a = 3'h0;
        d8 = 8'h0;
        l8 = 8'h0;
        rd(FS, 8'hf8);
        repeat (4) @(posedge clk);
        look();
        wrap_up();
    end
endmodule

// ### rtl/pfsg_gpio_bit.sv
`timescale 1ns/1ns
module pfsg_gpio_bit (
    input  wire logic gpio_sel_i,
    input  wire logic dir_i,
    input  wire logic latch_i,
    input  wire logic pin_i,
    input  wire logic fn_out_i,
    input  wire logic fn_oe_i,
    output logic      pin_out_o,
    output logic      pin_oe_o,
    output logic      read_o
);

    // ******************************************************************
    // one pin: general i/o or a peripheral function
    // ******************************************************************
    wire gpio_drive = gpio_sel_i & dir_i;

    // direction and latch set the drive only while the pin is general i/o; the data read uses them always
    assign pin_oe_o  = gpio_sel_i ? dir_i : fn_oe_i;
    // an input pin is never driven from the latch
    assign pin_out_o = gpio_sel_i ? (gpio_drive & latch_i)
                                  : (fn_oe_i & fn_out_i);
    // a data read shows the latch for outputs and the pin for inputs
    assign read_o    = dir_i ? latch_i : pin_i;

endmodule

// ### rtl/pfsg_pkg.sv
package pfsg_pkg;

    // ******************************************************************
    // widths
    // ******************************************************************
    localparam int APB_ADDR_W = 12;
    localparam int APB_DATA_W = 32;
    localparam int REG_W      = 8;
    localparam int PORTA_W    = 3;
    localparam int PORTB_W    = 8;

    // ******************************************************************
    // register byte addresses
    // ******************************************************************
    localparam logic [APB_ADDR_W-1:0] OFS_PORTA_FSEL = 12'h000;
    localparam logic [APB_ADDR_W-1:0] OFS_PORTA_DATA = 12'h004;
    localparam logic [APB_ADDR_W-1:0] OFS_PORTA_DIR  = 12'h008;
    localparam logic [APB_ADDR_W-1:0] OFS_PORTB_DATA = 12'h00C;
    localparam logic [APB_ADDR_W-1:0] OFS_PORTB_DIR  = 12'h010;

    // ******************************************************************
    // field positions of the port a function select register
    // ******************************************************************
    localparam int FSEL_TIMER_EVENT_IN = 0;
    localparam int FSEL_TIMER_LOW_OUT  = 1;
    localparam int FSEL_TIMER_HIGH_OUT = 2;
    localparam int PIN0                = 0;
    localparam int PIN1                = 1;
    localparam int PIN2                = 2;

    // ******************************************************************
    // reset and fixed read values
    // ******************************************************************
    localparam logic [PORTA_W-1:0] RST_PORTA   = 3'h0;
    localparam logic [PORTB_W-1:0] RST_PORTB   = 8'h00;
    localparam logic [REG_W-1:0]   PORTA_ONES  = 8'hF8;
    localparam logic [REG_W-1:0]   ALL_ONES    = 8'hFF;
    localparam logic [APB_DATA_W-1:0] RD_ZERO  = 32'h0000_0000;

    // ******************************************************************
    // idle levels of pins handed to peripherals
    // ******************************************************************
    localparam logic MARK_PLAIN    = 1'b1;
    localparam logic MARK_INFRARED = 1'b0;
    localparam logic IDLE_RX       = 1'b1;
    localparam logic IDLE_IN       = 1'b0;

endpackage

// ### rtl/pfsg_sync.sv
`timescale 1ns/1ns
module pfsg_sync #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // ******************************************************************
    // two flip-flop level synchroniser, frozen by the clock enable
    // ******************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (ce_i) begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;

endmodule

// ### rtl/pfsg_top.sv
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ns
module pfsg_top #(
    parameter int ADDR_W = pfsg_pkg::APB_ADDR_W
) (
    input  wire logic                         CLK_I,
    input  wire logic                         RST_N_I,
    input  wire logic                         CE_I,
    input  wire logic                         PSEL_I,
    input  wire logic                         PENABLE_I,
    input  wire logic                         PWRITE_I,
    input  wire logic [ADDR_W-1:0]            PADDR_I,
    input  wire logic [pfsg_pkg::APB_DATA_W-1:0] PWDATA_I,
    output logic      [pfsg_pkg::APB_DATA_W-1:0] PRDATA_O,
    output logic                              PREADY_O,
    output logic                              PSLVERR_O,
    input  wire logic                         INFRARED_SELECT_I,
    input  wire logic                         TX_ENABLE_I,
    input  wire logic                         RX_ENABLE_I,
    input  wire logic                         SERIAL_PIN_CONTROL_I,
    input  wire logic                         CLOCK_SOURCE_UPPER_I,
    input  wire logic                         CLOCK_SOURCE_LOWER_I,
    input  wire logic                         SYNC_MODE_I,
    input  wire logic                         SERIAL_TX_I,
    input  wire logic                         INFRARED_TX_I,
    input  wire logic                         SERIAL_CLOCK_OUT_I,
    input  wire logic                         TIMER_HIGH_OUT_I,
    input  wire logic                         TIMER_LOW_OUT_I,
    output logic                              SERIAL_RX_O,
    output logic                              INFRARED_RX_O,
    output logic                              SERIAL_CLOCK_IN_O,
    output logic                              TIMER_EVENT_IN_O,
    input  wire logic [pfsg_pkg::PORTA_W-1:0] PORT_A_IN_I,
    output logic      [pfsg_pkg::PORTA_W-1:0] PORT_A_OUT_O,
    output logic      [pfsg_pkg::PORTA_W-1:0] PORT_A_OE_O,
    input  wire logic [pfsg_pkg::PORTB_W-1:0] PORT_B_IN_I,
    output logic      [pfsg_pkg::PORTB_W-1:0] PORT_B_OUT_O,
    output logic      [pfsg_pkg::PORTB_W-1:0] PORT_B_OE_O
);

    localparam int AW = pfsg_pkg::PORTA_W;
    localparam int BW = pfsg_pkg::PORTB_W;
    localparam int DW = pfsg_pkg::APB_DATA_W;
    localparam int RW = pfsg_pkg::REG_W;

    // ******************************************************************
    // registers
    // ******************************************************************
    logic [AW-1:0] fsel_q;
    logic [AW-1:0] porta_latch_q;
    logic [AW-1:0] porta_dir_q;
    logic [BW-1:0] portb_latch_q;
    logic [BW-1:0] portb_dir_q;
    logic [DW-1:0] prdata_q;
    logic [DW-1:0] prdata_d;

    // ******************************************************************
    // pin synchronisers
    // ******************************************************************
    logic [AW+BW-1:0] pins_sync;
    wire  [AW-1:0]    porta_pin = pins_sync[AW-1:0];
    wire  [BW-1:0]    portb_pin = pins_sync[AW+BW-1:AW];

    pfsg_sync #(
        .W       (AW+BW)
    ) u_sync (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .ce_i    (CE_I),
        .d_i     ({PORT_B_IN_I, PORT_A_IN_I}),
        .q_o     (pins_sync)
    );

    // ******************************************************************
    // apb decode
    // ******************************************************************
    wire [ADDR_W-1:0] addr       = PADDR_I;
    wire hit_fsel  = (addr == ADDR_W'(pfsg_pkg::OFS_PORTA_FSEL));
    wire hit_adata = (addr == ADDR_W'(pfsg_pkg::OFS_PORTA_DATA));
    wire hit_adir  = (addr == ADDR_W'(pfsg_pkg::OFS_PORTA_DIR));
    wire hit_bdata = (addr == ADDR_W'(pfsg_pkg::OFS_PORTB_DATA));
    wire hit_bdir  = (addr == ADDR_W'(pfsg_pkg::OFS_PORTB_DIR));
    wire hit_any   = hit_fsel | hit_adata | hit_adir | hit_bdata | hit_bdir;
    wire setup_rd  = PSEL_I & ~PENABLE_I & ~PWRITE_I;
    wire access    = PSEL_I & PENABLE_I;
    wire wr_en     = CE_I & access & PWRITE_I & hit_any;
    wire [AW-1:0] wr_a = PWDATA_I[AW-1:0];
    wire [BW-1:0] wr_b = PWDATA_I[BW-1:0];

    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = access & ~hit_any;

    // ******************************************************************
    // port a function decode
    // ******************************************************************
    wire tmr_high = fsel_q[pfsg_pkg::FSEL_TIMER_HIGH_OUT];
    wire tmr_low  = fsel_q[pfsg_pkg::FSEL_TIMER_LOW_OUT];
    wire tmr_in   = fsel_q[pfsg_pkg::FSEL_TIMER_EVENT_IN];

    // pin2: timer output first, then serial transmit, else gpio
    wire p2_serial = ~tmr_high & SERIAL_PIN_CONTROL_I;
    wire p2_gpio   = ~tmr_high & ~SERIAL_PIN_CONTROL_I;
    wire tx_live   = INFRARED_SELECT_I ? INFRARED_TX_I : SERIAL_TX_I;
    wire tx_mark   = INFRARED_SELECT_I ? pfsg_pkg::MARK_INFRARED
                                       : pfsg_pkg::MARK_PLAIN;
    wire tx_val    = TX_ENABLE_I ? tx_live : tx_mark;
    wire p2_out    = tmr_high ? TIMER_HIGH_OUT_I : tx_val;

    // pin1: timer output first, then receive input, else gpio
    wire p1_rx     = ~tmr_low & RX_ENABLE_I;
    wire p1_gpio   = ~tmr_low & ~RX_ENABLE_I;

    // pin0: timer input first, then serial clock, else gpio
    wire cku       = CLOCK_SOURCE_UPPER_I;
    wire ckl       = CLOCK_SOURCE_LOWER_I;
    wire p0_ck_out = ~tmr_in & ~cku & (SYNC_MODE_I | ckl);
    wire p0_ck_in  = ~tmr_in & cku & ~ckl;
    // both clock sources set is prohibited: pin left undriven
    wire p0_gpio   = ~tmr_in & ~cku & ~ckl & ~SYNC_MODE_I;

    wire [AW-1:0] a_gpio  = {p2_gpio, p1_gpio, p0_gpio};
    wire [AW-1:0] a_fn_oe = {~p2_gpio, tmr_low, p0_ck_out};
    wire [AW-1:0] a_fn_dt = {p2_out, TIMER_LOW_OUT_I, SERIAL_CLOCK_OUT_I};

    // ******************************************************************
    // per-pin general i/o logic
    // ******************************************************************
    logic [AW-1:0] a_out;
    logic [AW-1:0] a_oe;
    logic [AW-1:0] a_rd;
    logic [BW-1:0] b_out;
    logic [BW-1:0] b_oe;
    logic [BW-1:0] b_rd;

    for (genvar i = 0; i < AW; i++) begin : g_porta
        pfsg_gpio_bit u_bit (
            .gpio_sel_i (a_gpio[i]),
            .dir_i      (porta_dir_q[i]),
            .latch_i    (porta_latch_q[i]),
            .pin_i      (porta_pin[i]),
            .fn_out_i   (a_fn_dt[i]),
            .fn_oe_i    (a_fn_oe[i]),
            .pin_out_o  (a_out[i]),
            .pin_oe_o   (a_oe[i]),
            .read_o     (a_rd[i])
        );
    end

    // port b carries only general i/o in this block
    for (genvar i = 0; i < BW; i++) begin : g_portb
        pfsg_gpio_bit u_bit (
            .gpio_sel_i (1'b1),
            .dir_i      (portb_dir_q[i]),
            .latch_i    (portb_latch_q[i]),
            .pin_i      (portb_pin[i]),
            .fn_out_i   (1'b0),
            .fn_oe_i    (1'b0),
            .pin_out_o  (b_out[i]),
            .pin_oe_o   (b_oe[i]),
            .read_o     (b_rd[i])
        );
    end

    // ******************************************************************
    // read data, captured in the setup phase
    // ******************************************************************
    wire [RW-1:0] rd_fsel  = pfsg_pkg::PORTA_ONES | RW'(fsel_q);
    wire [RW-1:0] rd_adata = pfsg_pkg::PORTA_ONES | RW'(a_rd);
    wire [RW-1:0] rd_bdata = b_rd;
    // direction registers are write-only
    wire [RW-1:0] rd_dir   = pfsg_pkg::ALL_ONES;

    always_comb begin
        prdata_d = pfsg_pkg::RD_ZERO;
        if (hit_fsel) begin
            prdata_d = DW'(rd_fsel);
        end else if (hit_adata) begin
            prdata_d = DW'(rd_adata);
        end else if (hit_bdata) begin
            prdata_d = DW'(rd_bdata);
        end else if (hit_adir | hit_bdir) begin
            prdata_d = DW'(rd_dir);
        end
    end

    // ******************************************************************
    // register writes
    // ******************************************************************
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            fsel_q        <= pfsg_pkg::RST_PORTA;
            porta_latch_q <= pfsg_pkg::RST_PORTA;
            porta_dir_q   <= pfsg_pkg::RST_PORTA;
            portb_latch_q <= pfsg_pkg::RST_PORTB;
            portb_dir_q   <= pfsg_pkg::RST_PORTB;
        end else if (wr_en) begin
            // only the low bits are stored, upper bits ignore writes
            if (hit_fsel) fsel_q <= wr_a;
            if (hit_adata) porta_latch_q <= wr_a;
            if (hit_adir) porta_dir_q <= wr_a;
            if (hit_bdata) portb_latch_q <= wr_b;
            if (hit_bdir) portb_dir_q <= wr_b;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            prdata_q <= pfsg_pkg::RD_ZERO;
        end else if (CE_I && setup_rd) begin
            prdata_q <= prdata_d;
        end
    end

    assign PRDATA_O = prdata_q;

    // ******************************************************************
    // pin and peripheral outputs
    // ******************************************************************
    wire rx_plain = p1_rx & ~INFRARED_SELECT_I ? porta_pin[pfsg_pkg::PIN1]
                                               : pfsg_pkg::IDLE_RX;
    wire rx_ir    = p1_rx & INFRARED_SELECT_I ? porta_pin[pfsg_pkg::PIN1]
                                              : pfsg_pkg::IDLE_RX;
    wire ck_in    = p0_ck_in ? porta_pin[pfsg_pkg::PIN0]
                             : pfsg_pkg::IDLE_IN;
    wire ev_in    = tmr_in ? porta_pin[pfsg_pkg::PIN0]
                           : pfsg_pkg::IDLE_IN;

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            PORT_A_OUT_O      <= pfsg_pkg::RST_PORTA;
            PORT_A_OE_O       <= pfsg_pkg::RST_PORTA;
            PORT_B_OUT_O      <= pfsg_pkg::RST_PORTB;
            PORT_B_OE_O       <= pfsg_pkg::RST_PORTB;
            SERIAL_RX_O       <= pfsg_pkg::IDLE_RX;
            INFRARED_RX_O     <= pfsg_pkg::IDLE_RX;
            SERIAL_CLOCK_IN_O <= pfsg_pkg::IDLE_IN;
            TIMER_EVENT_IN_O  <= pfsg_pkg::IDLE_IN;
        end else if (CE_I) begin
            PORT_A_OUT_O      <= a_out;
            PORT_A_OE_O       <= a_oe;
            PORT_B_OUT_O      <= b_out;
            PORT_B_OE_O       <= b_oe;
            SERIAL_RX_O       <= rx_plain;
            INFRARED_RX_O     <= rx_ir;
            SERIAL_CLOCK_IN_O <= ck_in;
            TIMER_EVENT_IN_O  <= ev_in;
        end
    end

    // ******************************************************************
    // assertions
    // ******************************************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    a_fsel_upper_ones: assert property (
        access && !PWRITE_I && hit_fsel |-> PRDATA_O[RW-1:AW] == 5'h1F)
        else $error("function select upper bits not read as one");

    a_dirb_reads_ones: assert property (
        access && !PWRITE_I && hit_bdir |-> PRDATA_O[RW-1:0] == 8'hFF)
        else $error("port b direction read not all ones");

    a_pin2_timer_wins: assert property (
        CE_I && tmr_high |=> PORT_A_OE_O[2]
            && PORT_A_OUT_O[2] == $past(TIMER_HIGH_OUT_I))
        else $error("pin2 not driving timer high output");

    a_tx_mark_state: assert property (
        CE_I && p2_serial && !TX_ENABLE_I
            |=> PORT_A_OE_O[2]
            && PORT_A_OUT_O[2] == !$past(INFRARED_SELECT_I))
        else $error("mark state level wrong on pin2");

    a_pin1_rx_input: assert property (
        CE_I && p1_rx |=> !PORT_A_OE_O[1])
        else $error("pin1 driven while used as receive input");

    a_pin0_timer_in: assert property (
        CE_I && tmr_in |=> !PORT_A_OE_O[0])
        else $error("pin0 driven while timer event input");

    a_pin0_clock_out: assert property (
        CE_I && p0_ck_out |=> PORT_A_OE_O[0]
            && PORT_A_OUT_O[0] == $past(SERIAL_CLOCK_OUT_I))
        else $error("pin0 not driving serial clock");

    a_gpio_input_quiet: assert property (
        CE_I && p2_gpio && !porta_dir_q[2] |=> !PORT_A_OE_O[2]
            && !PORT_A_OUT_O[2])
        else $error("gpio input pin2 driven");

    a_portb_drive: assert property (
        CE_I |=> PORT_B_OE_O == $past(portb_dir_q)
            && PORT_B_OUT_O == ($past(portb_dir_q) & $past(portb_latch_q)))
        else $error("port b drive not following direction and latch");

endmodule
